// >>> verilog/lbx_map.vh
// Purpose: Register map, opcode patterns and field positions for the
//          logic and branch execution block.
// Assumes: 16-bit instruction words, AXI4-Lite word-aligned registers.
// Notes:   Definitions only; included by bare name.
`ifndef LBX_MAP_VH
`define LBX_MAP_VH

// ***********************************************
// Register byte offsets
// ***********************************************
`define LBX_OFF_CTRL   8'h00
`define LBX_OFF_INSTR  8'h04
`define LBX_OFF_SRC    8'h08
`define LBX_OFF_DST    8'h0C
`define LBX_OFF_PC     8'h10
`define LBX_OFF_PSW    8'h14
`define LBX_OFF_RESULT 8'h18
`define LBX_OFF_STATUS 8'h1C

// ***********************************************
// Field positions
// ***********************************************
`define LBX_CTRL_GO    0
`define LBX_CC_N       3
`define LBX_CC_Z       2
`define LBX_CC_V       1
`define LBX_CC_C       0
`define LBX_ST_DONE    0
`define LBX_ST_WB      1
`define LBX_ST_TAKEN   2
`define LBX_ST_ILLEGAL 3
`define LBX_ST_BRANCH  4
`define LBX_SIGN_BIT   15
`define LBX_BSIGN_BIT  7
`define LBX_OFS_SIGN   7

// ***********************************************
// Opcode patterns (value and mask)
// ***********************************************
`define LBX_OPC_TAND   4'h3
`define LBX_OPC_CLRM   4'h4
`define LBX_OPC_SETM   4'h5
`define LBX_XOR_VAL    16'h7800
`define LBX_XOR_MASK   16'hFE00
`define LBX_JUMP_ALWAYS 8'h01
`define LBX_JUMP_NZ    8'h02
`define LBX_JUMP_Z     8'h03
`define LBX_JUMP_PLUS  8'h80
`define LBX_JUMP_MINUS 8'h81
`define LBX_JUMP_NOV   8'h84

// ***********************************************
// Constants and reset values
// ***********************************************
`define LBX_PC_STEP    16'h0002
`define LBX_RST_WORD   16'h0000
`define LBX_RST_CC     4'h0
`define LBX_RST_ST     5'h00
`define LBX_RESP_OKAY  2'b00
`define LBX_RESP_SLV   2'b10

`endif

// >>> verilog/lbx_logic_unit.v
// Purpose: Combinational bitwise logic group: test-AND, clear-masked,
//          set-masked and exclusive-OR, with condition-code results.
// Assumes: Operands already fetched; byte forms touch the low byte only.
// Notes:   Carry is passed through untouched for every op here.
`timescale 1ns/10ps
`include "lbx_map.vh"

module lbx_logic_unit #(
   parameter DW = 16
) (
   input wire [DW-1:0] i_instr,
   input wire [DW-1:0] i_src,
   input wire [DW-1:0] i_dst,
   input wire [3:0] i_cc,
   output reg o_is_logic,
   output reg o_wb,
   output reg [DW-1:0] o_result,
   output reg [3:0] o_cc
);

   // ***********************************************
   // Decode and compute
   // ***********************************************
   reg byte_mode;
   reg [DW-1:0] raw;
   reg [DW-1:0] res;
   reg neg;
   reg zer;

   // Pick the op, then form flags from the merged result
   always @* begin
      byte_mode = i_instr[DW-1];
      raw = i_dst;
      o_is_logic = 1'b1;
      o_wb = 1'b1;
      if ((i_instr & `LBX_XOR_MASK) == `LBX_XOR_VAL) begin
         raw = i_src ^ i_dst;
         byte_mode = 1'b0;
      end else if ({1'b0, i_instr[14:12]} == `LBX_OPC_TAND) begin
         raw = i_src & i_dst;
         o_wb = 1'b0;
      end else if ({1'b0, i_instr[14:12]} == `LBX_OPC_CLRM) begin
         raw = ~i_src & i_dst;
      end else if ({1'b0, i_instr[14:12]} == `LBX_OPC_SETM) begin
         raw = i_src | i_dst;
      end else begin
         o_is_logic = 1'b0;
         o_wb = 1'b0;
      end
      // Byte forms keep the destination's upper byte
      if (byte_mode)
         res = {i_dst[DW-1:8], raw[7:0]};
      else
         res = raw;
      if (byte_mode) begin
         neg = res[`LBX_BSIGN_BIT];
         zer = (res[7:0] == 8'h00);
      end else begin
         neg = res[`LBX_SIGN_BIT];
         zer = (res == {DW{1'b0}});
      end
      o_result = res;
      o_cc = i_cc;
      o_cc[`LBX_CC_N] = neg;
      o_cc[`LBX_CC_Z] = zer;
      o_cc[`LBX_CC_V] = 1'b0;
      o_cc[`LBX_CC_C] = i_cc[`LBX_CC_C];
   end

endmodule // lbx_logic_unit

// >>> verilog/lbx_exec.v
// Purpose: Logic and relative-branch execution unit behind AXI4-Lite.
// Assumes: Software loads instruction, operands, PC and flags, then
//          writes GO; results appear one cycle after the write commits.
// Notes:   Results commit in one cycle: PC for branches, flags for logic ops, destination for all logic ops but test-AND.
`timescale 1ns/10ps
`include "lbx_map.vh"

module lbx_exec #(
   parameter AW = 8,
   parameter DW = 16
) (
   input wire i_clk,
   input wire i_rstn,
   input wire [AW-1:0] i_awaddr,
   input wire i_awvalid,
   output wire o_awready,
   input wire [31:0] i_wdata,
   input wire [3:0] i_wstrb,
   input wire i_wvalid,
   output wire o_wready,
   output wire [1:0] o_bresp,
   output wire o_bvalid,
   input wire i_bready,
   input wire [AW-1:0] i_araddr,
   input wire i_arvalid,
   output wire o_arready,
   output wire [31:0] o_rdata,
   output wire [1:0] o_rresp,
   output wire o_rvalid,
   input wire i_rready
);

   // ***********************************************
   // Register state
   // ***********************************************
   reg [DW-1:0] instr_ff;
   reg [DW-1:0] src_ff;
   reg [DW-1:0] dst_ff;
   reg [DW-1:0] pc_ff;
   reg [DW-1:0] result_ff;
   reg [3:0] cc_ff;
   reg [4:0] status_ff;
   reg go_ff;

   // AXI handshake state
   reg awready_ff;
   reg wready_ff;
   reg aw_full_ff;
   reg w_full_ff;
   reg [AW-1:0] awaddr_ff;
   reg [31:0] wdata_ff;
   reg [3:0] wstrb_ff;
   reg bvalid_ff;
   reg [1:0] bresp_ff;
   reg arready_ff;
   reg rvalid_ff;
   reg [31:0] rdata_ff;
   reg [1:0] rresp_ff;

   assign o_awready = awready_ff;
   assign o_wready = wready_ff;
   assign o_bvalid = bvalid_ff;
   assign o_bresp = bresp_ff;
   assign o_arready = arready_ff;
   assign o_rvalid = rvalid_ff;
   assign o_rdata = rdata_ff;
   assign o_rresp = rresp_ff;

   // ***********************************************
   // Byte-lane merge
   // ***********************************************
   // Only the two low lanes exist; upper lanes are dropped silently
   function [DW-1:0] lbx_merge;
      input [DW-1:0] old;
      input [31:0] data;
      input [3:0] strb;
      begin
         lbx_merge = old;
         if (strb[0])
            lbx_merge[7:0] = data[7:0];
         if (strb[1])
            lbx_merge[15:8] = data[15:8];
      end
   endfunction

   // ***********************************************
   // Write channel
   // ***********************************************
   wire aw_hs = i_awvalid & awready_ff;
   wire w_hs = i_wvalid & wready_ff;
   wire do_wr = aw_full_ff & w_full_ff & ~bvalid_ff;
   wire [AW-1:0] wr_word = {awaddr_ff[AW-1:2], 2'b00};
   wire wr_mapped = (wr_word == `LBX_OFF_CTRL) |
                    (wr_word == `LBX_OFF_INSTR) |
                    (wr_word == `LBX_OFF_SRC) |
                    (wr_word == `LBX_OFF_DST) |
                    (wr_word == `LBX_OFF_PC) |
                    (wr_word == `LBX_OFF_PSW) |
                    (wr_word == `LBX_OFF_RESULT) |
                    (wr_word == `LBX_OFF_STATUS);
   wire wr_go = do_wr & (wr_word == `LBX_OFF_CTRL) &
                wstrb_ff[0] & wdata_ff[`LBX_CTRL_GO];

   reg nxt_aw_full;
   reg nxt_w_full;
   reg nxt_bvalid;

   // Address and data are held separately so they may come in any order
   always @* begin
      nxt_aw_full = aw_full_ff;
      nxt_w_full = w_full_ff;
      nxt_bvalid = bvalid_ff;
      if (aw_hs)
         nxt_aw_full = 1'b1;
      if (w_hs)
         nxt_w_full = 1'b1;
      if (do_wr) begin
         nxt_aw_full = 1'b0;
         nxt_w_full = 1'b0;
         nxt_bvalid = 1'b1;
      end
      if (bvalid_ff & i_bready)
         nxt_bvalid = 1'b0;
   end

   // Handshake registers; ready drops while a slot is occupied
   always @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         aw_full_ff <= 1'b0;
         w_full_ff <= 1'b0;
         bvalid_ff <= 1'b0;
         bresp_ff <= `LBX_RESP_OKAY;
         awready_ff <= 1'b0;
         wready_ff <= 1'b0;
         awaddr_ff <= {AW{1'b0}};
         wdata_ff <= 32'h0000_0000;
         wstrb_ff <= 4'h0;
      end else begin
         aw_full_ff <= nxt_aw_full;
         w_full_ff <= nxt_w_full;
         bvalid_ff <= nxt_bvalid;
         awready_ff <= ~nxt_aw_full & ~nxt_bvalid;
         wready_ff <= ~nxt_w_full & ~nxt_bvalid;
         if (aw_hs)
            awaddr_ff <= i_awaddr;
         if (w_hs) begin
            wdata_ff <= i_wdata;
            wstrb_ff <= i_wstrb;
         end
         if (do_wr)
            bresp_ff <= wr_mapped ? `LBX_RESP_OKAY : `LBX_RESP_SLV;
      end
   end

   // ***********************************************
   // Execution datapath
   // ***********************************************
   wire lu_is_logic;
   wire lu_wb;
   wire [DW-1:0] lu_result;
   wire [3:0] lu_cc;

   lbx_logic_unit #(
      .DW(DW)
   ) u_logic (
      .i_instr(instr_ff),
      .i_src(src_ff),
      .i_dst(dst_ff),
      .i_cc(cc_ff),
      .o_is_logic(lu_is_logic),
      .o_wb(lu_wb),
      .o_result(lu_result),
      .o_cc(lu_cc)
   );

   wire [7:0] jump_code = instr_ff[15:8];
   wire [7:0] jump_ofs = instr_ff[7:0];
   // Sign-extended, doubled offset: -256..+254 bytes
   wire [DW-1:0] jump_delta = {{(DW-9){jump_ofs[`LBX_OFS_SIGN]}},
                               jump_ofs, 1'b0};
   wire [DW-1:0] pc_upd = pc_ff + `LBX_PC_STEP;
   wire [DW-1:0] jump_target = pc_upd + jump_delta;

   reg is_branch;
   reg jump_cond;

   // Condition select; branch codes take priority over logic decode
   always @* begin
      is_branch = 1'b1;
      jump_cond = 1'b0;
      case (jump_code)
         `LBX_JUMP_ALWAYS: jump_cond = 1'b1;
         `LBX_JUMP_NZ: jump_cond = ~cc_ff[`LBX_CC_Z];
         `LBX_JUMP_Z: jump_cond = cc_ff[`LBX_CC_Z];
         `LBX_JUMP_PLUS: jump_cond = ~cc_ff[`LBX_CC_N];
         `LBX_JUMP_MINUS: jump_cond = cc_ff[`LBX_CC_N];
         `LBX_JUMP_NOV: jump_cond = ~cc_ff[`LBX_CC_V];
         default: is_branch = 1'b0;
      endcase
   end

   // ***********************************************
   // Register file writes and execution commit
   // ***********************************************
   // Execution runs the cycle after GO, so a GO write never races the
   // operand writes before it; done set cannot meet its clear.
   always @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         instr_ff <= `LBX_RST_WORD;
         src_ff <= `LBX_RST_WORD;
         dst_ff <= `LBX_RST_WORD;
         pc_ff <= `LBX_RST_WORD;
         result_ff <= `LBX_RST_WORD;
         cc_ff <= `LBX_RST_CC;
         status_ff <= `LBX_RST_ST;
         go_ff <= 1'b0;
      end else begin
         go_ff <= wr_go;
         if (do_wr) begin
            case (wr_word)
               `LBX_OFF_INSTR: instr_ff <= lbx_merge(instr_ff, wdata_ff,
                                                     wstrb_ff);
               `LBX_OFF_SRC: src_ff <= lbx_merge(src_ff, wdata_ff,
                                                 wstrb_ff);
               `LBX_OFF_DST: dst_ff <= lbx_merge(dst_ff, wdata_ff,
                                                 wstrb_ff);
               `LBX_OFF_PC: pc_ff <= lbx_merge(pc_ff, wdata_ff,
                                               wstrb_ff);
               `LBX_OFF_PSW: begin
                  if (wstrb_ff[0])
                     cc_ff <= wdata_ff[3:0];
               end
               default: begin
               end
            endcase
         end
         if (wr_go)
            status_ff <= `LBX_RST_ST; // Fresh run clears sticky status
         if (go_ff) begin
            status_ff[`LBX_ST_DONE] <= 1'b1;
            status_ff[`LBX_ST_BRANCH] <= is_branch;
            if (is_branch) begin
               // Flags untouched by any branch
               status_ff[`LBX_ST_TAKEN] <= jump_cond;
               status_ff[`LBX_ST_WB] <= 1'b0;
               if (jump_cond)
                  pc_ff <= jump_target;
               else
                  pc_ff <= pc_upd;
            end else if (lu_is_logic) begin
               cc_ff <= lu_cc;
               status_ff[`LBX_ST_WB] <= lu_wb;
               if (lu_wb)
                  dst_ff <= lu_result;
               result_ff <= lu_result;
            end else begin
               status_ff[`LBX_ST_ILLEGAL] <= 1'b1;
            end
         end
      end
   end

   // ***********************************************
   // Read channel
   // ***********************************************
   wire ar_hs = i_arvalid & arready_ff;
   wire [AW-1:0] rd_word = {i_araddr[AW-1:2], 2'b00};
   reg [31:0] rd_mux;
   reg rd_ok;

   // Read decode; CTRL reads zero since GO is a pulse
   always @* begin
      rd_mux = 32'h0000_0000;
      rd_ok = 1'b1;
      case (rd_word)
         `LBX_OFF_CTRL: rd_mux = 32'h0000_0000;
         `LBX_OFF_INSTR: rd_mux = {16'h0000, instr_ff};
         `LBX_OFF_SRC: rd_mux = {16'h0000, src_ff};
         `LBX_OFF_DST: rd_mux = {16'h0000, dst_ff};
         `LBX_OFF_PC: rd_mux = {16'h0000, pc_ff};
         `LBX_OFF_PSW: rd_mux = {28'h0000000, cc_ff};
         `LBX_OFF_RESULT: rd_mux = {16'h0000, result_ff};
         `LBX_OFF_STATUS: rd_mux = {27'h0000000, status_ff};
         default: rd_ok = 1'b0;
      endcase
   end

   wire nxt_rvalid = ar_hs | (rvalid_ff & ~i_rready);

   // One read in flight; arready returns once the data is taken
   always @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         arready_ff <= 1'b0;
         rvalid_ff <= 1'b0;
         rdata_ff <= 32'h0000_0000;
         rresp_ff <= `LBX_RESP_OKAY;
      end else begin
         rvalid_ff <= nxt_rvalid;
         arready_ff <= ~nxt_rvalid;
         if (ar_hs) begin
            rdata_ff <= rd_mux;
            rresp_ff <= rd_ok ? `LBX_RESP_OKAY : `LBX_RESP_SLV;
         end
      end
   end

endmodule // lbx_exec

// >>> bench/lbx_exec_asserts.sv
// Purpose: Bus handshake checks for the logic and branch unit.
// Assumes: One clock, reset active low.
// Notes: Sees only top ports; answer timing is this design's own.
`timescale 1ns/10ps
`include "lbx_map.vh"
// ****************
// Checker
// ****************
module lbx_exec_chk #(
   parameter AW = 8
) (
   input wire i_clk,
   input wire i_rstn,
   input wire i_awvalid,
   input wire o_awready,
   input wire i_wvalid,
   input wire o_wready,
   input wire [1:0] o_bresp,
   input wire o_bvalid,
   input wire i_bready,
   input wire [AW-1:0] i_araddr,
   input wire i_arvalid,
   input wire o_arready,
   input wire [31:0] o_rdata,
   input wire [1:0] o_rresp,
   input wire o_rvalid,
   input wire i_rready
);
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_rstn);
   // Both write halves taken on one edge
   sequence s_wr_take;
      i_awvalid && o_awready && i_wvalid && o_wready;
   endsequence
   sequence s_rd_take;
      i_arvalid && o_arready;
   endsequence
   // Answer two edges after the write is taken
   a_write_answer: assert property (s_wr_take |=> !o_bvalid ##1 o_bvalid)
      else $error("write answer not on time");
   a_read_answer: assert property (s_rd_take |=> o_rvalid)
      else $error("read answer not on time");
   // Answers stand until taken
   a_bvalid_holds: assert property (o_bvalid && !i_bready |=>
      o_bvalid && $stable(o_bresp)) else $error("write answer dropped");
   a_rvalid_holds: assert property (o_rvalid && !i_rready |=>
      o_rvalid && $stable(o_rdata)) else $error("read answer dropped");
   a_b_once: assert property (o_bvalid && i_bready |=> !o_bvalid)
      else $error("write answer repeated");
   a_ar_blocked: assert property (o_rvalid |-> !o_arready)
      else $error("read accepted while busy");
   // Holes in the map answer with an error and zero data
   a_unmapped_rd: assert property ((s_rd_take and (i_araddr >= 8'h20)) |=>
      o_rresp == `LBX_RESP_SLV && o_rdata == 32'h0)
      else $error("unmapped read not refused");
   a_mapped_rd: assert property ((s_rd_take and (i_araddr < 8'h20)) |=>
      o_rresp == `LBX_RESP_OKAY && o_rdata[31:16] == 16'h0)
      else $error("mapped read answer wrong");
endmodule // lbx_exec_chk

bind lbx_exec lbx_exec_chk #(.AW(AW)) u_chk (
   .i_clk(i_clk), .i_rstn(i_rstn), .i_awvalid(i_awvalid),
   .o_awready(o_awready), .i_wvalid(i_wvalid), .o_wready(o_wready),
   .o_bresp(o_bresp), .o_bvalid(o_bvalid), .i_bready(i_bready),
   .i_araddr(i_araddr), .i_arvalid(i_arvalid), .o_arready(o_arready),
   .o_rdata(o_rdata), .o_rresp(o_rresp), .o_rvalid(o_rvalid),
   .i_rready(i_rready));

// >>> bench/lbx_exec_tb.sv
// Purpose: Self-checking bench for the logic and branch unit.
// Assumes: Registers reached over the register bus only.
// Notes: Byte lanes all enabled except one lane-1-only DST write; operands loaded before each GO.
`timescale 1ns/10ps
`include "lbx_map.vh"
module testbench;
   reg i_clk = 0;
   reg i_rstn = 0;
   reg [7:0] i_awaddr = 0;
   reg [7:0] i_araddr = 0;
   reg [31:0] i_wdata = 0;
   reg [3:0] i_wstrb = 4'hF;
   reg i_awvalid = 0, i_wvalid = 0, i_bready = 0;
   reg i_arvalid = 0, i_rready = 0;
   wire o_awready, o_wready, o_bvalid, o_arready, o_rvalid;
   wire [1:0] o_bresp, o_rresp;
   wire [31:0] o_rdata;
   integer bad_count = 0, samples_checked = 0, cyc = 0, j, k;
   reg [1:0] rsp;
   reg [31:0] rv;
   reg [15:0] s_v, ep;
   reg [3:0] f, mk;
   reg [7:0] cd;
   reg tk;
   reg [4:0] est_v;
   // Branch codes with the flag each tests and the sense it wants
   localparam [47:0] CODES = 48'h010203808184;
   localparam [23:0] MASKS = 24'h044882;
   localparam [5:0] SENSE = 6'b001010;
   lbx_exec DUT (
      .i_clk(i_clk), .i_rstn(i_rstn), .i_awaddr(i_awaddr),
      .i_awvalid(i_awvalid), .o_awready(o_awready),
      .i_wdata(i_wdata), .i_wstrb(i_wstrb), .i_wvalid(i_wvalid),
      .o_wready(o_wready), .o_bresp(o_bresp), .o_bvalid(o_bvalid),
      .i_bready(i_bready), .i_araddr(i_araddr),
      .i_arvalid(i_arvalid), .o_arready(o_arready),
      .o_rdata(o_rdata), .o_rresp(o_rresp), .o_rvalid(o_rvalid),
      .i_rready(i_rready));
   // ****************
   // Bus tasks
   // ****************
   // Halves released as each is taken; wait ends on the answer
   task wr(input [7:0] a, input [31:0] d);
      @(posedge i_clk);
      i_awaddr <= a;
      i_wdata <= d;
      i_awvalid <= 1;
      i_wvalid <= 1;
      i_bready <= 1;
      do begin
         @(posedge i_clk);
         if (o_awready) i_awvalid <= 0;
         if (o_wready) i_wvalid <= 0;
      end while (o_bvalid !== 1'b1);
      rsp = o_bresp;
      i_bready <= 0;
   endtask
   task rd(input [7:0] a);
      @(posedge i_clk);
      i_araddr <= a;
      i_arvalid <= 1;
      i_rready <= 1;
      do begin
         @(posedge i_clk);
         if (o_arready) i_arvalid <= 0;
      end while (o_rvalid !== 1'b1);
      rv = o_rdata;
      rsp = o_rresp;
      i_rready <= 0;
   endtask
   task chk(input string nm, input [31:0] e, input [31:0] g);
      samples_checked = samples_checked + 1;
      if (g !== e) begin
         bad_count = bad_count + 1;
         $display("wrong value %s exp %h got %h", nm, e, g);
      end
   endtask
   // Load one instruction with its operands and start it
   task go(input [15:0] i, s, d, p, input [3:0] fl);
      s_v = s;
      wr(`LBX_OFF_INSTR, {16'h0, i});
      wr(`LBX_OFF_SRC, {16'h0, s});
      wr(`LBX_OFF_DST, {16'h0, d});
      wr(`LBX_OFF_PC, {16'h0, p});
      wr(`LBX_OFF_PSW, {28'h0, fl});
      wr(`LBX_OFF_CTRL, 32'h1);
   endtask
   // Source must never change, whatever ran
   task look(input [15:0] ed, epc, input [3:0] ef, input [4:0] est);
      rd(`LBX_OFF_SRC);
      chk("src", {16'h0, s_v}, rv);
      rd(`LBX_OFF_DST);
      chk("dst", {16'h0, ed}, rv);
      rd(`LBX_OFF_PC);
      chk("pc", {16'h0, epc}, rv);
      rd(`LBX_OFF_PSW);
      chk("psw", {28'h0, ef}, rv);
      rd(`LBX_OFF_STATUS);
      chk("status", {27'h0, est}, rv);
   endtask
   task close_out;
      if (bad_count == 0 && samples_checked > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask
   // ****************
   // Clock, watchdog and tests
   // ****************
   initial begin
      forever #2.5 i_clk = ~i_clk;
   end
   // Whole run needs well under this many cycles
   always @(posedge i_clk) begin
      cyc = cyc + 1;
      if (cyc == 30000) begin
         bad_count = bad_count + 1;
         close_out;
      end
   end
   initial begin
      repeat (4) @(posedge i_clk);
      i_rstn <= 1;
      repeat (2) @(posedge i_clk);
      rd(`LBX_OFF_PC);
      chk("pc reset", 32'h0, rv);
      rd(8'h40);
      chk("hole rresp", 32'h2, {30'h0, rsp});
      chk("hole rdata", 32'h0, rv);
      wr(8'h40, 32'h5);
      chk("hole bresp", 32'h2, {30'h0, rsp});
      go(16'h3000, 16'h0018, 16'h0010, 16'h0100, 4'hF);
      look(16'h0010, 16'h0100, 4'h1, 5'h01);
      rd(`LBX_OFF_RESULT);
      chk("result", 32'h10, rv);
      wr(`LBX_OFF_RESULT, 32'h1234);
      chk("result bresp", 32'h0, {30'h0, rsp});
      rd(`LBX_OFF_RESULT);
      chk("result ro", 32'h10, rv);
      go(16'h3000, 16'h8000, 16'h0001, 16'h0, 4'h2);
      look(16'h0001, 16'h0, 4'h4, 5'h01);
      go(16'h4000, 16'h029C, 16'h0249, 16'h0100, 4'hF);
      look(16'h0041, 16'h0100, 4'h1, 5'h03);
      go(16'h4000, 16'h0001, 16'h8001, 16'h0, 4'h0);
      look(16'h8000, 16'h0, 4'h8, 5'h03);
      go(16'h5000, 16'h029C, 16'h0249, 16'h0, 4'h7);
      look(16'h02DD, 16'h0, 4'h1, 5'h03);
      go(16'h7800, 16'h029C, 16'h0249, 16'h0, 4'hF);
      look(16'h00D5, 16'h0, 4'h1, 5'h03);
      go(16'h7800, 16'h8000, 16'h0, 16'h0, 4'h0);
      look(16'h8000, 16'h0, 4'h8, 5'h03);
      go(16'h7800, 16'h5A5A, 16'h5A5A, 16'h0, 4'h3);
      look(16'h0, 16'h0, 4'h5, 5'h03);
      // Byte forms: upper destination byte kept, flags from low byte
      go(16'hD000, 16'h029C, 16'hA549, 16'h0, 4'h1);
      look(16'hA5DD, 16'h0, 4'h9, 5'h03);
      go(16'hC000, 16'h00FF, 16'h12F0, 16'h0, 4'h0);
      look(16'h1200, 16'h0, 4'h4, 5'h03);
      // Unknown opcode only marks status
      go(16'h0000, 16'h1, 16'h2, 16'h0100, 4'h6);
      look(16'h2, 16'h0100, 4'h6, 5'h09);
      // Lane 1 alone reaches the upper byte only
      i_wstrb <= 4'h2;
      wr(`LBX_OFF_DST, 32'h0000_ABCD);
      i_wstrb <= 4'hF;
      rd(`LBX_OFF_DST);
      chk("dst lane", 32'hAB02, rv);
      // A small negative offset and both offset extremes around one branch address
      go(16'h01FD, 16'h1, 16'h2, 16'h0140, 4'hA);
      look(16'h2, 16'h013C, 4'hA, 5'h15);
      go(16'h017F, 16'h1, 16'h2, 16'h0140, 4'h5);
      look(16'h2, 16'h0240, 4'h5, 5'h15);
      go(16'h0180, 16'h1, 16'h2, 16'h0140, 4'hF);
      look(16'h2, 16'h0042, 4'hF, 5'h15);
      // Every branch code with its flag clear and then set
      for (j = 5; j >= 0; j = j - 1) begin
         for (k = 0; k < 2; k = k + 1) begin
            cd = CODES[j*8 +: 8];
            mk = MASKS[j*4 +: 4];
            f = k ? 4'hF : 4'h0;
            tk = (mk == 4'h0) || (((f & mk) != 4'h0) == SENSE[j]);
            ep = tk ? 16'h020A : 16'h0202;
            est_v = tk ? 5'h15 : 5'h11;
            go({cd, 8'h04}, 16'h1, 16'h2, 16'h200, f);
            look(16'h2, ep, f, est_v);
         end
      end
      rd(`LBX_OFF_CTRL);
      chk("ctrl reads", 32'h0, rv);
      close_out;
   end
endmodule // testbench
